// File: inc/port_one_pkg.sv
package port_one_pkg;
  localparam logic [7:0] ADDR_LATCH = 8'h00;
  localparam logic [7:0] ADDR_LATCH_RMW = 8'h04;
  localparam logic [7:0] ADDR_DIR = 8'h08;
  localparam logic [7:0] ADDR_PULLUP = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_PINS = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_HIZ_BIT = 1;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [2:0] a_clock_sel;
    logic [2:0] b_clock_sel;
    logic a_out_en;
    logic b_out_en;
    logic a_clock;
    logic b_clock;
    logic a_data;
    logic b_data;
  } serial_drive_t;

  typedef struct packed {
    logic a_clock;
    logic b_clock;
    logic a_data;
    logic b_data;
  } serial_in_t;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] pin_direction_bits;
    logic [7:0] pullup_disable_bits;
    logic port_enable_bit;
    logic hiz_allow_bit;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage

// File: hdl/port_one_gpio.sv
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module port_one_gpio
  import port_one_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic power_float_request,
  input wire serial_drive_t serial_drive,
  output serial_in_t serial_in,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n,
  output logic [7:0] pullup_on
);
  state_t q, d;
  logic [7:0] drive_mask;
  logic [7:0] drive_val;
  logic floating;
  logic do_write;
  // write address and data, either just taken or held from an earlier edge
  logic [7:0] wa;
  logic [31:0] wd;

  // pins whose output is overridden by a serial block
  function automatic logic [7:0] override_mask(input serial_drive_t s);
    logic [7:0] m;
    m = 8'h00;
    m[0] = (s.a_clock_sel != 3'b000);
    m[3] = (s.b_clock_sel != 3'b000);
    m[2] = s.a_out_en;
    m[5] = s.b_out_en;
    return m;
  endfunction

  // pad control; float request with hiz allowed wins over everything, disable over direction
  always_comb begin
    logic [7:0] ovr;
    ovr = override_mask(serial_drive);
    floating = q.hiz_allow_bit & power_float_request;
    drive_mask = 8'h00;
    if (q.port_enable_bit && !floating) begin
      drive_mask = ovr | q.pin_direction_bits;
    end
    drive_val = q.latch;
    if (ovr[0]) drive_val[0] = serial_drive.a_clock;
    if (ovr[3]) drive_val[3] = serial_drive.b_clock;
    if (ovr[2]) drive_val[2] = serial_drive.a_data;
    if (ovr[5]) drive_val[5] = serial_drive.b_data;
    pin_o = drive_val;
    pin_oe_n = ~drive_mask;
    // output pins and floated pins never get a pull-up
    pullup_on = (floating || !q.port_enable_bit) ? 8'h00 :
      ~q.pullup_disable_bits & ~drive_mask;
  end

  // serial inputs see synchronised pin levels only on input-mode pins
  always_comb begin
    logic [7:0] inp;
    inp = q.port_enable_bit ? ~drive_mask : 8'h00;
    serial_in.a_clock = inp[0] & q.sync2[0];
    serial_in.a_data = inp[1] & q.sync2[1];
    serial_in.b_clock = inp[3] & q.sync2[3];
    serial_in.b_data = inp[4] & q.sync2[4];
  end

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign do_write = (q.aw_got || s_axi_awvalid) && (q.w_got || s_axi_wvalid) && !q.bvalid;
  // held item wins so a late partner cannot change a half-taken write
  assign wa = q.aw_got ? q.aw_addr : s_axi_awaddr;
  assign wd = q.w_got ? q.w_data : s_axi_wdata;

  // next state: bus slave, register file, pin synchroniser
  always_comb begin
    d = q;
    d.sync1 = pin_i;
    d.sync2 = q.sync1;
    if (s_axi_awready && s_axi_awvalid) begin
      d.aw_got = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wready && s_axi_wvalid) begin
      d.w_got = 1'b1;
      d.w_data = s_axi_wdata;
    end
    if (do_write) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        unique case (wa)
          ADDR_LATCH, ADDR_LATCH_RMW: d.latch = wd[7:0];
          ADDR_DIR: d.pin_direction_bits = wd[7:0];
          ADDR_PULLUP: d.pullup_disable_bits = wd[7:0];
          ADDR_CTRL: begin
            d.port_enable_bit = wd[CTRL_EN_BIT];
            d.hiz_allow_bit = wd[CTRL_HIZ_BIT];
          end
          ADDR_PINS: ;
          default: d.bresp = RESP_SLVERR;
        endcase
      end else if (!(wa inside {ADDR_LATCH, ADDR_LATCH_RMW, ADDR_DIR, ADDR_PULLUP,
          ADDR_CTRL, ADDR_PINS})) begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) d.bvalid = 1'b0;
    if (s_axi_arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp = RESP_OKAY;
      d.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_LATCH: d.rdata[7:0] = q.sync2;
        ADDR_LATCH_RMW: d.rdata[7:0] = q.latch;
        ADDR_DIR: d.rdata[7:0] = q.pin_direction_bits;
        ADDR_PULLUP: d.rdata[7:0] = q.pullup_disable_bits;
        ADDR_CTRL: begin
          d.rdata[CTRL_EN_BIT] = q.port_enable_bit;
          d.rdata[CTRL_HIZ_BIT] = q.hiz_allow_bit;
        end
        ADDR_PINS: d.rdata[7:0] = q.sync2;
        default: d.rresp = RESP_SLVERR;
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.latch <= LATCH_RESET;
      q.pin_direction_bits <= DIR_RESET;
      q.pullup_disable_bits <= PULLUP_RESET;
      q.port_enable_bit <= 1'b0;
    end else begin
      q <= d;
    end
  end

  property p_disabled_floats;
    @(posedge aclk) disable iff (!aresetn)
      !q.port_enable_bit |-> (pin_oe_n == 8'hff) && (pullup_on == 8'h00);
  endproperty
  a_disabled_floats: assert property (p_disabled_floats) else $error("pins driven while disabled");

  property p_dir_drives;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && !floating) |-> ((~pin_oe_n & q.pin_direction_bits) == q.pin_direction_bits);
  endproperty
  a_dir_drives: assert property (p_dir_drives) else $error("output pin not driven");

  property p_float;
    @(posedge aclk) disable iff (!aresetn)
      floating |-> (pin_oe_n == 8'hff) && (pullup_on == 8'h00);
  endproperty
  a_float: assert property (p_float) else $error("pin not floated");

  property p_out_no_pullup;
    @(posedge aclk) disable iff (!aresetn)
      (pullup_on & ~pin_oe_n) == 8'h00;
  endproperty
  a_out_no_pullup: assert property (p_out_no_pullup) else $error("pull-up on driven pin");

  property p_pullup_follows;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && !floating) |->
        ((pullup_on | ~pin_oe_n) == (~q.pullup_disable_bits | ~pin_oe_n));
  endproperty
  a_pullup_follows: assert property (p_pullup_follows) else $error("pull-up mismatch");

  property p_clock_override;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && !floating && serial_drive.a_clock_sel != 3'b000) |->
        !pin_oe_n[0] && (pin_o[0] == serial_drive.a_clock);
  endproperty
  a_clock_override: assert property (p_clock_override) else $error("clock override missing");

  property p_data_override;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && !floating && serial_drive.b_out_en) |->
        !pin_oe_n[5] && (pin_o[5] == serial_drive.b_data);
  endproperty
  a_data_override: assert property (p_data_override) else $error("data override missing");

  property p_reset_values;
    @(posedge aclk) $rose(aresetn) |->
      q.pin_direction_bits == DIR_RESET && q.pullup_disable_bits == PULLUP_RESET;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset values");

  sequence s_rmw_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_LATCH_RMW;
  endsequence
  property p_rmw_latch;
    @(posedge aclk) disable iff (!aresetn)
      s_rmw_read |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(q.latch);
  endproperty
  a_rmw_latch: assert property (p_rmw_latch) else $error("rmw read not latch");

  // plain pin reads return the synchronised levels, never the latch
  sequence s_pin_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_LATCH;
  endsequence
  property p_pin_read;
    @(posedge aclk) disable iff (!aresetn)
      s_pin_read |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(q.sync2);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("pin read not pins");

  // register writes land at the edge after the write completes
  sequence s_dir_write;
    do_write && s_axi_wstrb[0] && wa == ADDR_DIR;
  endsequence
  property p_dir_write;
    @(posedge aclk) disable iff (!aresetn)
      s_dir_write |=> q.pin_direction_bits == $past(wd[7:0]);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  sequence s_pullup_write;
    do_write && s_axi_wstrb[0] && wa == ADDR_PULLUP;
  endsequence
  property p_pullup_write;
    @(posedge aclk) disable iff (!aresetn)
      s_pullup_write |=> q.pullup_disable_bits == $past(wd[7:0]);
  endproperty
  a_pullup_write: assert property (p_pullup_write) else $error("pull-up write lost");

  sequence s_ctrl_write;
    do_write && s_axi_wstrb[0] && wa == ADDR_CTRL;
  endsequence
  property p_ctrl_write;
    @(posedge aclk) disable iff (!aresetn)
      s_ctrl_write |=> q.port_enable_bit == $past(wd[CTRL_EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable write lost");

  // enable must come back low from every reset, not only the first
  property p_enable_reset;
    @(posedge aclk) $rose(aresetn) |-> !q.port_enable_bit && q.latch == LATCH_RESET;
  endproperty
  a_enable_reset: assert property (p_enable_reset) else $error("enable not cleared");

  // disabled port hands nothing to the serial blocks
  property p_serial_gated;
    @(posedge aclk) disable iff (!aresetn)
      !q.port_enable_bit |-> serial_in == '0;
  endproperty
  a_serial_gated: assert property (p_serial_gated) else $error("serial input leaked");

  // input-mode clock pin feeds the serial clock input
  property p_serial_in_follow;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && pin_oe_n[0]) |-> serial_in.a_clock == q.sync2[0];
  endproperty
  a_serial_in_follow: assert property (p_serial_in_follow) else $error("serial input lost");

  // an output pin is a port output only, its serial input stays quiet
  property p_serial_out_quiet;
    @(posedge aclk) disable iff (!aresetn)
      !pin_oe_n[1] |-> !serial_in.a_data;
  endproperty
  a_serial_out_quiet: assert property (p_serial_out_quiet) else $error("output fed serial");

  property p_clock_b_override;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && !floating && serial_drive.b_clock_sel != 3'b000) |->
        !pin_oe_n[3] && (pin_o[3] == serial_drive.b_clock);
  endproperty
  a_clock_b_override: assert property (p_clock_b_override) else $error("clock b missing");

  property p_data_a_override;
    @(posedge aclk) disable iff (!aresetn)
      (q.port_enable_bit && !floating && serial_drive.a_out_en) |->
        !pin_oe_n[2] && (pin_o[2] == serial_drive.a_data);
  endproperty
  a_data_a_override: assert property (p_data_a_override) else $error("data a missing");

  // a pending response blocks new write items
  property p_write_busy;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_busy: assert property (p_write_busy) else $error("write taken while busy");

  // the response stands until the master takes it
  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  property p_rdata_hold;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data dropped");
endmodule

// File: sim/pin_model.sv
`timescale 1ns/100ps
// pads plus board: a driven pin shows the port, else the board, else pull-up or noise
module pin_model (
  input wire logic aclk,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n,
  input wire logic [7:0] pullup_on,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_i
);
  logic [7:0] noise_q = 8'h55;
  // a floating pin toggles so a stale level never passes for a real one
  always_ff @(posedge aclk) begin
    noise_q <= ~noise_q;
  end
  assign pin_i = (pin_o & ~pin_oe_n) | (ext_val & ext_en & pin_oe_n)
    | (pin_oe_n & ~ext_en & (pullup_on | noise_q));
endmodule

// File: sim/port_one_gpio_tb.sv
`timescale 1ns/100ps
module port_one_gpio_tb;
  import port_one_pkg::*;
  logic aclk, aresetn, ta, tw, tb;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ext_en, ext_val, pin_i, pin_o, pin_oe_n, pullup_on;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_b;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic power_float_request;
  serial_drive_t serial_drive;
  serial_in_t serial_in;
  int fail_count, n_tests;
  port_one_gpio dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_float_request, .serial_drive,
    .serial_in, .pin_i, .pin_o, .pin_oe_n, .pullup_on);
  pin_model pm_u (.aclk, .pin_o, .pin_oe_n, .pullup_on, .ext_en, .ext_val, .pin_i);
  initial begin
    aclk = 0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ready is looked at mid-cycle; inputs only move at rising edges, so it is the edge value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      wr_b = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
    end while (!tb);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do begin
      @(negedge aclk);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 0;
    end while (!tb);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rd_d, e);
  endtask
  // hang guard, far beyond the fewer than a hundred cycles the sequence needs
  initial begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end
  initial begin
    {aresetn, s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid, power_float_request, serial_drive} = '0;
    {ext_en, ext_val, fail_count, n_tests} = '0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1; // responses always accepted at once
    s_axi_rready = 1;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    rchk(ADDR_DIR, 0);
    rchk(ADDR_PULLUP, 8'hff);
    rchk(ADDR_CTRL, 0);
    wr(ADDR_DIR, 8'hff);
    serial_drive <= '1;
    @(negedge aclk);
    chk(pin_oe_n, 8'hff);
    chk(pullup_on, 0);
    @(posedge aclk);
    serial_drive <= '0;
    ext_en <= 8'hf0;
    ext_val <= 8'h3c;
    wr(ADDR_CTRL, 1);
    wr(ADDR_LATCH, 8'ha5);
    wr(ADDR_DIR, 8'h0f);
    @(negedge aclk);
    chk(pin_oe_n, 8'hf0);
    chk(pin_o[3:0], 4'h5);
    chk(pullup_on, 0);
    wr(ADDR_PULLUP, 0);
    repeat (3) @(negedge aclk);
    chk(pullup_on, 8'hf0);
    rchk(ADDR_LATCH, 8'h35);
    rchk(ADDR_LATCH_RMW, 8'ha5);
    ext_en <= 8'hff;
    ext_val <= 8'h0b;
    wr(ADDR_DIR, 0);
    repeat (3) @(negedge aclk);
    chk(serial_in, 4'he);
    rchk(ADDR_PINS, 8'h0b);
    wr(ADDR_DIR, 8'h1b);
    repeat (3) @(negedge aclk);
    chk(serial_in, 0);
    wr(ADDR_DIR, 0);
    serial_drive <= 12'h2b9;
    @(negedge aclk);
    chk(pin_oe_n, 8'hd2);
    chk(pin_o & 8'h2d, 8'h21);
    wr(ADDR_CTRL, 3);
    power_float_request <= 1;
    @(negedge aclk);
    chk(pin_oe_n, 8'hff);
    chk(pullup_on, 0);
    rd(8'h20);
    chk(rd_r, RESP_SLVERR);
    wr(8'h20, 0);
    chk(wr_b, RESP_SLVERR);
    give_verdict();
  end
endmodule
